// ### hw/sfr_top.sv
`timescale 1ns/100ps
`include "sfr_params.svh"
module sfr_top #(
  parameter int NREGS = `SFR_NUM_REGS,
  parameter int REG_W = `SFR_REG_W
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Instruction issue
  input wire logic i_valid,
  input wire sfr_pkg::sfr_ref_e i_ref_kind,
  input wire logic i_p64_ref,
  input wire logic i_empty_op,
  input wire logic i_fp_push,
  input wire logic i_fp_op,
  input wire logic i_wide_op,
  input wire logic [5:0] i_addr_lo,
  // Shared register write
  input wire logic i_wr_en,
  input wire logic i_wr_fp_view,
  input wire logic [`SFR_IDX_W-1:0] i_wr_idx,
  input wire logic [REG_W-1:0] i_wr_data,
  // Shared register read
  input wire logic [`SFR_IDX_W-1:0] i_rd_idx,
  output logic [REG_W-1:0] o_rd_data,
  // Status
  output logic o_ready,
  output logic [NREGS-1:0] o_tag_valid,
  output logic o_stack_ovf,
  output logic o_align_fault,
  output logic o_busy
);
  // ----------------------------------------
  // Alignment check
  // ----------------------------------------
  sfr_align_if aif ();
  assign aif.kind = i_valid ? i_ref_kind : sfr_pkg::SFR_REF_NONE;
  assign aif.addr_lo = i_addr_lo;
  sfr_align_chk u_align (
    .a(aif)
  );

  // ----------------------------------------
  // Shared storage
  // ----------------------------------------
  // One array serves both views, so either view sees the other's writes
  logic [REG_W-1:0] regs_r [NREGS];
  logic [REG_W-1:0] regs_nxt [NREGS];
  logic [NREGS-1:0] tag_r, tag_nxt;
  logic ovf_r, ovf_nxt, afault_r, afault_nxt;
  logic [REG_W-1:0] rd_r, rd_nxt;
  sfr_pkg::sfr_state_e st_r, st_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic accept;

  // Stall only for emptying or a misaligned 64-bit or unaligned-move access
  assign o_ready = (st_r == sfr_pkg::SFR_IDLE);
  assign accept = i_valid & o_ready;

  always_comb begin
    regs_nxt = regs_r;
    // Wide writes use their own file and never land here
    if (accept && i_wr_en && !i_wide_op) begin
      regs_nxt[i_wr_idx] = i_wr_data;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int k = 0; k < NREGS; k++) begin
        regs_r[k] <= '0;
      end
    end else begin
      regs_r <= regs_nxt;
    end
  end

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // Push marks the lowest empty slot valid; tags fill from bit 0 up
  function automatic logic [NREGS-1:0] push_fill(input logic [NREGS-1:0] t);
    push_fill = t | (t << 1) | {{(NREGS-1){1'b0}}, 1'b1};
  endfunction

  function automatic logic stack_full(input logic [NREGS-1:0] t);
    stack_full = &t;
  endfunction

  logic take_shared;
  logic emptying_go;
  logic fill_go;
  logic push_go;
  logic split_go;
  logic empty_done;

  // Wide ops of any data type bypass the shared registers and tags; split stalls and alignment faults still apply to them
  assign take_shared = accept & ~i_wide_op;
  assign emptying_go = take_shared & i_empty_op;
  assign fill_go = take_shared & ~i_empty_op & i_p64_ref;
  assign push_go = take_shared & ~i_empty_op & ~i_p64_ref & i_fp_push;
  // Empty outranks the split stall so its sequence is never cut short
  assign split_go = accept & aif.split & ~aif.fault & ~emptying_go;
  assign empty_done = (st_r == sfr_pkg::SFR_EMPTYING) && (cnt_r == 3'h0);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // One down-counter serves both stalls; only one can run at a time.
  // While it runs o_ready is low, so no float op can slip in early.
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    case (st_r)
      sfr_pkg::SFR_IDLE: begin
        if (emptying_go) begin
          // Tags stay full until the sequence ends; no fp op may issue
          st_nxt = sfr_pkg::SFR_EMPTYING;
          cnt_nxt = `SFR_EMPTY_CYCLES - 3'h1;
        end else if (split_go) begin
          // Split access completes with an extra cycle, no exception
          st_nxt = sfr_pkg::SFR_SPLIT;
          cnt_nxt = {1'b0, `SFR_SPLIT_CYCLES} - 3'h1;
        end
      end
      sfr_pkg::SFR_EMPTYING: begin
        if (cnt_r == 3'h0) begin
          st_nxt = sfr_pkg::SFR_IDLE;
        end else begin
          cnt_nxt = cnt_r - 3'h1;
        end
      end
      sfr_pkg::SFR_SPLIT: begin
        if (cnt_r == 3'h0) begin
          st_nxt = sfr_pkg::SFR_IDLE;
        end else begin
          cnt_nxt = cnt_r - 3'h1;
        end
      end
      default: st_nxt = sfr_pkg::SFR_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r <= sfr_pkg::SFR_IDLE;
      cnt_r <= 3'h0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ----------------------------------------
  // Tag word
  // ----------------------------------------
  always_comb begin
    tag_nxt = tag_r;
    if (empty_done) begin
      tag_nxt = `SFR_TAG_EMPTY;
    end else if (fill_go) begin
      tag_nxt = `SFR_TAG_ALL_VALID;
    end else if (push_go && !stack_full(tag_r)) begin
      // Overflowing push leaves the tag word as it was
      tag_nxt = push_fill(tag_r);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tag_r <= `SFR_TAG_EMPTY;
    end else begin
      tag_r <= tag_nxt;
    end
  end

  // ----------------------------------------
  // Exceptions and read port
  // ----------------------------------------
  // Both flags are one-cycle pulses; the core latches them itself
  always_comb begin
    ovf_nxt = push_go & stack_full(tag_r);
    afault_nxt = accept & aif.fault;
    rd_nxt = regs_r[i_rd_idx];
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ovf_r <= 1'b0;
      afault_r <= 1'b0;
      rd_r <= '0;
    end else begin
      ovf_r <= ovf_nxt;
      afault_r <= afault_nxt;
      rd_r <= rd_nxt;
    end
  end

  // Mismatched-type wide ops are computed elsewhere, bit-exact
  assign o_rd_data = rd_r;
  assign o_tag_valid = tag_r;
  assign o_stack_ovf = ovf_r;
  assign o_align_fault = afault_r;
  assign o_busy = ~o_ready;
  // Float-op and view flags steer nothing here; both views share storage
  logic unused_fp;
  assign unused_fp = i_fp_op | i_wr_fp_view;
endmodule // sfr_top

// ### hw/sfr_params.svh
`ifndef SFR_PARAMS_SVH
`define SFR_PARAMS_SVH
`define SFR_NUM_REGS 8
`define SFR_REG_W 64
`define SFR_IDX_W 3
`define SFR_TAG_ALL_VALID 8'hFF
`define SFR_TAG_EMPTY 8'h00
`define SFR_ALIGN64_MASK 6'h07
`define SFR_ALIGN128_MASK 6'h0F
`define SFR_EMPTY_CYCLES 3'h3
`define SFR_SPLIT_CYCLES 2'h1
`define SFR_LINE_BYTES_LOG2 6
`endif

// ### hw/sfr_pkg.sv
package sfr_pkg;
  typedef enum logic [1:0] {
    SFR_IDLE = 2'h0,
    SFR_EMPTYING = 2'h1,
    SFR_SPLIT = 2'h3
  } sfr_state_e;
  typedef enum logic [1:0] {
    SFR_REF_NONE = 2'h0,
    SFR_REF_P64 = 2'h1,
    SFR_REF_P128 = 2'h2,
    SFR_REF_P128U = 2'h3
  } sfr_ref_e;
endpackage

// ### hw/sfr_align_if.sv
`timescale 1ns/100ps
interface sfr_align_if;
  logic [1:0] kind;
  logic [5:0] addr_lo;
  logic fault;
  logic split;
  modport chk (input kind, input addr_lo, output fault, output split);
  modport use_side (output kind, output addr_lo, input fault, input split);
endinterface

// ### hw/sfr_align_chk.sv
`timescale 1ns/100ps
`include "sfr_params.svh"
module sfr_align_chk (
  sfr_align_if.chk a
);
  function automatic logic misaligned(input logic [5:0] ad, input logic [5:0] m);
    misaligned = |(ad & m);
  endfunction
  always_comb begin
    a.fault = 1'b0;
    a.split = 1'b0;
    case (a.kind)
      sfr_pkg::SFR_REF_P128: a.fault = misaligned(a.addr_lo, `SFR_ALIGN128_MASK);
      // Unaligned move completes, split lines cost an extra cycle
      sfr_pkg::SFR_REF_P128U: a.split = misaligned(a.addr_lo, `SFR_ALIGN128_MASK);
      sfr_pkg::SFR_REF_P64: a.split = misaligned(a.addr_lo, `SFR_ALIGN64_MASK);
      default: a.split = 1'b0;
    endcase
  end
endmodule // sfr_align_chk

// ### testbench/sfr_top_asserts.sv
`timescale 1ns/100ps
// --
// Port checks
// --
module sfr_top_asserts #(parameter int NREGS = 8) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_valid,
  input wire sfr_pkg::sfr_ref_e i_ref_kind,
  input wire logic i_p64_ref,
  input wire logic i_empty_op,
  input wire logic i_fp_push,
  input wire logic i_wide_op,
  input wire logic [5:0] i_addr_lo,
  input wire logic o_ready,
  input wire logic [NREGS-1:0] o_tag_valid,
  input wire logic o_stack_ovf,
  input wire logic o_align_fault
);
  wire tk = i_valid && o_ready;
  wire ne = tk && !i_empty_op;
  wire nw = ne && !i_wide_op;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  AST_FILL: assert property (nw && i_p64_ref |=> &o_tag_valid)
    else $error("fill");
  AST_EMPTY: assert property (tk && i_empty_op && !i_wide_op |=>
    !o_ready [*3] ##1 o_ready && !o_tag_valid) else $error("empty");
  AST_OVF: assert property (nw && !i_p64_ref && i_fp_push && &o_tag_valid |=> o_stack_ovf)
    else $error("ovf");
  AST_A128: assert property (ne && i_ref_kind == sfr_pkg::SFR_REF_P128 &&
    i_addr_lo[3:0] != 0 |=> o_align_fault) else $error("a128");
  // Kinds 1 and 3 share bit 0: 64-bit and unaligned move
  AST_NOFLT: assert property (ne && i_ref_kind[0] |=> !o_align_fault)
    else $error("nofault");
  AST_SPLIT: assert property (ne && i_ref_kind == sfr_pkg::SFR_REF_P64 &&
    i_addr_lo[2:0] != 0 |=> !o_ready ##1 o_ready) else $error("split");
  AST_B2B: assert property (nw && i_p64_ref && i_ref_kind == sfr_pkg::SFR_REF_NONE |=> o_ready)
    else $error("b2b");
  AST_WIDE: assert property (tk && i_wide_op |=> $stable(o_tag_valid))
    else $error("wide");
  cover property (tk && i_empty_op);
  cover property (o_stack_ovf);
  cover property (o_align_fault);
endmodule // sfr_top_asserts

// ### testbench/sfr_top_bench.sv
`timescale 1ns/100ps
// --
// Bench
// --
module sfr_top_bench;
  logic i_core_clk, i_rstn, i_valid, i_p64_ref, i_empty_op, i_fp_push, i_fp_op, i_wide_op;
  logic i_wr_en, i_wr_fp_view, o_ready, o_stack_ovf, o_align_fault, o_busy;
  logic [2:0] i_wr_idx, i_rd_idx;
  logic [5:0] i_addr_lo;
  logic [63:0] i_wr_data, o_rd_data;
  logic [7:0] o_tag_valid;
  sfr_pkg::sfr_ref_e i_ref_kind;
  int fail_count = 0, samples_checked = 0, cyc = 0;
  sfr_top u_sfr_top (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_valid(i_valid),
    .i_ref_kind(i_ref_kind),
    .i_p64_ref(i_p64_ref),
    .i_empty_op(i_empty_op),
    .i_fp_push(i_fp_push),
    .i_fp_op(i_fp_op),
    .i_wide_op(i_wide_op),
    .i_addr_lo(i_addr_lo),
    .i_wr_en(i_wr_en),
    .i_wr_fp_view(i_wr_fp_view),
    .i_wr_idx(i_wr_idx),
    .i_wr_data(i_wr_data),
    .i_rd_idx(i_rd_idx),
    .o_rd_data(o_rd_data),
    .o_ready(o_ready),
    .o_tag_valid(o_tag_valid),
    .o_stack_ovf(o_stack_ovf),
    .o_align_fault(o_align_fault),
    .o_busy(o_busy)
  );
  initial begin
    i_core_clk = 0;
    forever #2 i_core_clk = ~i_core_clk;
  end
  task chk(input string n, input logic [63:0] e, input logic [63:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task summarize;
    $display("checked %0d failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Flags: packed ref, empty, push, wide
  task op(input logic [3:0] f, input sfr_pkg::sfr_ref_e k, input logic [5:0] a);
    @(posedge i_core_clk);
    i_valid <= 1;
    {i_p64_ref, i_empty_op, i_fp_push, i_wide_op} <= f;
    i_ref_kind <= k;
    i_addr_lo <= a;
    @(posedge i_core_clk);
    i_valid <= 0;
    #1;
  endtask
  task t_alias;
    @(posedge i_core_clk);
    {i_valid, i_wr_en, i_wr_fp_view, i_wr_idx, i_wr_data} <= {6'h3D, 64'hA55A_0FF0_1234_9876};
    @(posedge i_core_clk);
    {i_valid, i_wr_en, i_rd_idx} <= 5'h05;
    @(posedge i_core_clk);
    #1;
    chk("rd", 64'hA55A_0FF0_1234_9876, o_rd_data);
    $display("alias done");
  endtask
  task t_tags;
    op(4'h8, sfr_pkg::SFR_REF_NONE, 6'h00);
    chk("tag", 64'hFF, 64'(o_tag_valid));
    chk("rdy", 64'h1, 64'(o_ready));
    op(4'h2, sfr_pkg::SFR_REF_NONE, 6'h00);
    chk("ovf", 64'h1, 64'(o_stack_ovf));
    // Empty is issued before the next float push, as software must
    op(4'h4, sfr_pkg::SFR_REF_NONE, 6'h00);
    chk("busy", 64'h0, 64'(o_ready));
    chk("busy", 64'h1, 64'(o_busy));
    repeat (3) @(posedge i_core_clk);
    #1;
    chk("tag", 64'h0, 64'({o_ready, o_tag_valid} ^ 9'h100));
    op(4'h2, sfr_pkg::SFR_REF_NONE, 6'h00);
    chk("tag", 64'h01, 64'({o_stack_ovf, o_tag_valid}));
    op(4'h9, sfr_pkg::SFR_REF_NONE, 6'h00);
    chk("tag", 64'h01, 64'(o_tag_valid));
    $display("tags done");
  endtask
  task t_align;
    op(4'h0, sfr_pkg::SFR_REF_P128, 6'h08);
    chk("flt", 64'h1, 64'(o_align_fault));
    op(4'h0, sfr_pkg::SFR_REF_P128U, 6'h08);
    chk("flt", 64'h0, 64'(o_align_fault));
    op(4'h0, sfr_pkg::SFR_REF_P64, 6'h03);
    chk("flt", 64'h0, 64'({o_ready, o_align_fault}));
    @(posedge i_core_clk);
    #1;
    chk("rdy", 64'h1, 64'(o_ready));
    $display("align done");
  endtask
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 500) begin
      fail_count++;
      summarize;
    end
  end
  initial begin
    {i_rstn, i_valid, i_p64_ref, i_empty_op, i_fp_push, i_fp_op, i_wide_op} = 7'h0;
    {i_wr_en, i_wr_fp_view, i_wr_idx, i_rd_idx, i_addr_lo, i_wr_data} = 78'h0;
    i_ref_kind = sfr_pkg::SFR_REF_NONE;
    repeat (3) @(posedge i_core_clk);
    i_rstn <= 1;
    t_alias;
    t_tags;
    t_align;
    summarize;
  end
endmodule // sfr_top_bench
bind sfr_top sfr_top_asserts #(.NREGS(NREGS)) u_sfr_top_asserts (
  .i_core_clk(i_core_clk),
  .i_rstn(i_rstn),
  .i_valid(i_valid),
  .i_ref_kind(i_ref_kind),
  .i_p64_ref(i_p64_ref),
  .i_empty_op(i_empty_op),
  .i_fp_push(i_fp_push),
  .i_wide_op(i_wide_op),
  .i_addr_lo(i_addr_lo),
  .o_ready(o_ready),
  .o_tag_valid(o_tag_valid),
  .o_stack_ovf(o_stack_ovf),
  .o_align_fault(o_align_fault)
);
